// ---- src/sev_pkg.sv ----
// Constants shared by the status event register block.
package sev_pkg;

   // ********************************************************************
   // Register widths and bit positions
   // ********************************************************************
   localparam int REG_W = 16;
   localparam int NUM_TGT = 4;
   localparam int NUM_EVT = 3;
   localparam int BIT_B1 = 1;
   localparam int BIT_B2 = 2;

   // ********************************************************************
   // Register targets selected by a command
   // ********************************************************************
   localparam logic [1:0] TGT_OPERATION = 2'h0;
   localparam logic [1:0] TGT_TRIGGER   = 2'h1;
   localparam logic [1:0] TGT_ARM       = 2'h2;
   localparam logic [1:0] TGT_SEQUENCE  = 2'h3;

   // ********************************************************************
   // Implemented bits per target: operation, trigger, arm, sequence
   // ********************************************************************
   localparam logic [15:0] MASK_OPERATION = 16'h0462;
   localparam logic [15:0] MASK_TRIGGER   = 16'h0002;
   localparam logic [15:0] MASK_ARM       = 16'h0002;
   localparam logic [15:0] MASK_SEQUENCE  = 16'h0006;
   localparam logic [NUM_TGT-1:0][15:0] USED_MASK =
      {MASK_SEQUENCE, MASK_ARM, MASK_TRIGGER, MASK_OPERATION};

   // ********************************************************************
   // Reset and preset values
   // ********************************************************************
   localparam logic [15:0] ENABLE_RESET = 16'h0000;
   localparam logic [15:0] EVENT_RESET  = 16'h0000;
   localparam logic [15:0] ZERO_WORD    = 16'h0000;

   // ********************************************************************
   // Command kinds
   // ********************************************************************
   localparam logic [3:0] CMD_QUERY_EVENT  = 4'h0;
   localparam logic [3:0] CMD_WRITE_ENABLE = 4'h1;
   localparam logic [3:0] CMD_QUERY_ENABLE = 4'h2;
   localparam logic [3:0] CMD_WRITE_RISE   = 4'h3;
   localparam logic [3:0] CMD_QUERY_RISE   = 4'h4;
   localparam logic [3:0] CMD_WRITE_FALL   = 4'h5;
   localparam logic [3:0] CMD_QUERY_FALL   = 4'h6;
   localparam logic [3:0] CMD_PRESET       = 4'h7;
   localparam logic [3:0] CMD_CLEAR_STATUS = 4'h8;
   localparam logic [3:0] CMD_QUERY_COND   = 4'h9;

endpackage

// ---- src/sev_event_reg.sv ----
// One edge-filtered, read-cleared event register with its summary bit.
`timescale 1ns/1ps
module sev_event_reg #(
   parameter int          WIDTH = 16,
   parameter logic [15:0] USED  = 16'h0002
) (
   input  wire logic             clk_sys,
   input  wire logic             srst,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] cond,
   input  wire logic [WIDTH-1:0] rise_en,
   input  wire logic [WIDTH-1:0] fall_en,
   input  wire logic [WIDTH-1:0] enable,
   input  wire logic             clear,
   output logic      [WIDTH-1:0] events,
   output logic                  summary
);

   // ********************************************************************
   // Edge detection
   // ********************************************************************
   logic [WIDTH-1:0] cond_prev;
   logic [WIDTH-1:0] hits;
   logic [WIDTH-1:0] kept;
   logic [WIDTH-1:0] next_events;

   // A rising filter catches 0-to-1, a falling filter 1-to-0 changes.
   assign hits = ((cond & ~cond_prev & rise_en) |
                  (~cond & cond_prev & fall_en)) & USED[WIDTH-1:0];
   // A read clears the old bits, but a hit in that cycle still lands.
   assign kept = clear ? '0 : events;
   assign next_events = kept | hits;

   // Event bits and condition history.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         events    <= '0;
         cond_prev <= '0;
      end else if (ce) begin
         events    <= next_events;
         cond_prev <= cond;
      end
   end

   // Summary follows the unmasked event bits only.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         summary <= 1'b0;
      end else if (ce) begin
         summary <= |(next_events & enable);
      end
   end

endmodule

// ---- src/sev_status_events.sv ----
// Trigger, arm and sequence event registers with their enable masks.
//
// Functional notes
// - Trigger event B1 records entering or leaving the trigger layer per filter.
// - Trigger and arm event bits other than B1 never report events.
// - Arm event B1 records entering or leaving the arm layers per filter.
// - Sequence event B1 records entering or leaving arm layer one per filter.
// - Sequence event B2 records entering or leaving arm layer two per filter.
// - Sequence event bits other than B1 and B2 never report events.
// - An enable write loads the value's bit pattern; zero clears it.
// - Value weights 2, 4, 32, 64, 1024 map to bits B1, B2, B5, B6, B10.
// - Reset and preset clear enables; clear-status leaves them alone.
// - An enable query returns the register's current bit pattern.
// - A cleared enable bit keeps its event from the summary.
// - A set enable bit lets its event set the summary.
// - Reading an event register returns it and then clears it.
// - Rising filter sets on 0-to-1, falling filter on 1-to-0.
`timescale 1ns/1ps
module sev_status_events #(
   parameter int WIDTH = 16
) (
   input  wire logic             clk_sys,
   input  wire logic             srst,
   input  wire logic             ce,
   input  wire logic             cmd_valid,
   input  wire logic [3:0]       cmd_kind,
   input  wire logic [1:0]       cmd_target,
   input  wire logic [WIDTH-1:0] cmd_value,
   input  wire logic             layer_active_flag,
   input  wire logic             arm_layer_flag,
   input  wire logic             arm_stage_one_flag,
   input  wire logic             arm_stage_two_flag,
   output logic                  rsp_valid,
   output logic      [WIDTH-1:0] rsp_value,
   output logic                  trig_summary,
   output logic                  arm_summary,
   output logic                  seq_summary
);

   // ********************************************************************
   // Command decode
   // ********************************************************************
   localparam int NUM_TGT = sev_pkg::NUM_TGT;
   localparam int NUM_EVT = sev_pkg::NUM_EVT;

   logic               do_write_enable;
   logic               do_write_rise;
   logic               do_write_fall;
   logic               do_preset;
   logic               do_clear_status;
   logic               do_query_event;
   logic               is_query;
   logic [NUM_TGT-1:0] tgt_hit;

   // Write, preset, clear-status and event-query kinds each become one qualified strobe.
   assign do_write_enable = cmd_valid && cmd_kind == sev_pkg::CMD_WRITE_ENABLE;
   assign do_write_rise   = cmd_valid && cmd_kind == sev_pkg::CMD_WRITE_RISE;
   assign do_write_fall   = cmd_valid && cmd_kind == sev_pkg::CMD_WRITE_FALL;
   assign do_preset       = cmd_valid && cmd_kind == sev_pkg::CMD_PRESET;
   assign do_clear_status = cmd_valid && cmd_kind == sev_pkg::CMD_CLEAR_STATUS;
   assign do_query_event  = cmd_valid && cmd_kind == sev_pkg::CMD_QUERY_EVENT;
   // Every query kind gets exactly one answer on the next cycle.
   assign is_query = cmd_valid && (cmd_kind == sev_pkg::CMD_QUERY_EVENT  ||
                                   cmd_kind == sev_pkg::CMD_QUERY_ENABLE ||
                                   cmd_kind == sev_pkg::CMD_QUERY_RISE   ||
                                   cmd_kind == sev_pkg::CMD_QUERY_FALL   ||
                                   cmd_kind == sev_pkg::CMD_QUERY_COND);

   // ********************************************************************
   // Enable registers, one per target
   // ********************************************************************
   logic [NUM_TGT-1:0][WIDTH-1:0] enab;

   genvar t;
   generate
      for (t = 0; t < NUM_TGT; t++) begin : g_enable
         assign tgt_hit[t] = (cmd_target == 2'(t));

         // Enables load the value's binary pattern, limited to used bits.
         always_ff @(posedge clk_sys) begin
            if (srst) begin
               enab[t] <= sev_pkg::ENABLE_RESET;
            end else if (ce) begin
               if (do_preset) begin
                  enab[t] <= sev_pkg::ENABLE_RESET;
               end else if (do_write_enable && tgt_hit[t]) begin
                  enab[t] <= cmd_value & sev_pkg::USED_MASK[t][WIDTH-1:0];
               end
            end
         end
      end
   endgenerate

   // ********************************************************************
   // Transition filters and event registers
   // ********************************************************************
   logic [NUM_EVT-1:0][WIDTH-1:0] rise_filt;
   logic [NUM_EVT-1:0][WIDTH-1:0] fall_filt;
   logic [NUM_EVT-1:0][WIDTH-1:0] cond_vec;
   logic [NUM_EVT-1:0][WIDTH-1:0] evt_bits;
   logic [NUM_EVT-1:0]            evt_clear;
   logic [NUM_EVT-1:0]            evt_summary;

   // Live conditions placed at their documented bit positions.
   always_comb begin
      cond_vec = '0;
      cond_vec[0][sev_pkg::BIT_B1] = layer_active_flag;
      cond_vec[1][sev_pkg::BIT_B1] = arm_layer_flag;
      cond_vec[2][sev_pkg::BIT_B1] = arm_stage_one_flag;
      cond_vec[2][sev_pkg::BIT_B2] = arm_stage_two_flag;
   end

   genvar e;
   generate
      for (e = 0; e < NUM_EVT; e++) begin : g_event
         // Event register e belongs to target e plus one.
         assign evt_clear[e] = do_clear_status || (do_query_event && tgt_hit[e+1]);

         // Filters start on rising edges for every used bit.
         always_ff @(posedge clk_sys) begin
            if (srst) begin
               rise_filt[e] <= sev_pkg::USED_MASK[e+1][WIDTH-1:0];
               fall_filt[e] <= sev_pkg::ZERO_WORD[WIDTH-1:0];
            end else if (ce) begin
               if (do_preset) begin
                  rise_filt[e] <= sev_pkg::USED_MASK[e+1][WIDTH-1:0];
                  fall_filt[e] <= sev_pkg::ZERO_WORD[WIDTH-1:0];
               end else begin
                  if (do_write_rise && tgt_hit[e+1]) begin
                     rise_filt[e] <= cmd_value & sev_pkg::USED_MASK[e+1][WIDTH-1:0];
                  end
                  if (do_write_fall && tgt_hit[e+1]) begin
                     fall_filt[e] <= cmd_value & sev_pkg::USED_MASK[e+1][WIDTH-1:0];
                  end
               end
            end
         end

         sev_event_reg #(
            .WIDTH (WIDTH),
            .USED  (sev_pkg::USED_MASK[e+1])
         ) u_event (
            .clk_sys (clk_sys),
            .srst    (srst),
            .ce      (ce),
            .cond    (cond_vec[e]),
            .rise_en (rise_filt[e]),
            .fall_en (fall_filt[e]),
            .enable  (enab[e+1]),
            .clear   (evt_clear[e]),
            .events  (evt_bits[e]),
            .summary (evt_summary[e])
         );
      end
   endgenerate

   // ********************************************************************
   // Query answer selection
   // ********************************************************************
   logic [WIDTH-1:0] sel_event;
   logic [WIDTH-1:0] sel_rise;
   logic [WIDTH-1:0] sel_fall;
   logic [WIDTH-1:0] sel_cond;
   logic [WIDTH-1:0] next_rsp_value;
   logic             tgt_is_op;
   logic [1:0]       evt_idx;

   // The operation event register is not held here and reads as zero.
   assign tgt_is_op = (cmd_target == sev_pkg::TGT_OPERATION);
   assign evt_idx   = cmd_target - 2'h1;
   assign sel_event = tgt_is_op ? '0 : evt_bits[evt_idx];
   assign sel_rise  = tgt_is_op ? '0 : rise_filt[evt_idx];
   assign sel_fall  = tgt_is_op ? '0 : fall_filt[evt_idx];
   assign sel_cond  = tgt_is_op ? '0 : cond_vec[evt_idx];

   // Pick the word that matches the query kind.
   always_comb begin
      case (cmd_kind)
         sev_pkg::CMD_QUERY_EVENT:  next_rsp_value = sel_event;
         sev_pkg::CMD_QUERY_ENABLE: next_rsp_value = enab[cmd_target];
         sev_pkg::CMD_QUERY_RISE:   next_rsp_value = sel_rise;
         sev_pkg::CMD_QUERY_FALL:   next_rsp_value = sel_fall;
         sev_pkg::CMD_QUERY_COND:   next_rsp_value = sel_cond;
         default:                   next_rsp_value = '0;
      endcase
   end

   // ********************************************************************
   // Registered outputs
   // ********************************************************************

   // Answer stands for one cycle; the value holds until the next query.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rsp_valid <= 1'b0;
         rsp_value <= '0;
      end else if (ce) begin
         rsp_valid <= is_query;
         if (is_query) begin
            rsp_value <= next_rsp_value;
         end
      end
   end

   // Summaries for the next register set come from the event flops.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         trig_summary <= 1'b0;
         arm_summary  <= 1'b0;
         seq_summary  <= 1'b0;
      end else if (ce) begin
         trig_summary <= evt_summary[0];
         arm_summary  <= evt_summary[1];
         seq_summary  <= evt_summary[2];
      end
   end

endmodule

// ---- dv/sev_host_model.sv ----
// Host model that issues status commands on the command port.
`timescale 1ns/1ps
module sev_host_model (
   input  wire logic        clk_sys,
   output logic             cmd_valid,
   output logic      [3:0]  cmd_kind,
   output logic      [1:0]  cmd_target,
   output logic      [15:0] cmd_value
);
   // The port starts idle.
   initial begin
      cmd_valid = 1'b0;
      cmd_kind = 4'h0;
      cmd_target = 2'h0;
      cmd_value = 16'h0000;
   end
   // Presents one command; the strobe stays up so commands can follow back to back.
   task automatic send(input logic [3:0] k, input logic [1:0] t, input logic [15:0] v);
      @(posedge clk_sys);
      #1;
      cmd_valid = 1'b1;
      cmd_kind = k;
      cmd_target = t;
      cmd_value = v;
   endtask
   // Drops the strobe; released fields change so stale values are never trusted.
   task automatic idle();
      @(posedge clk_sys);
      #1;
      cmd_valid = 1'b0;
      cmd_kind = ~cmd_kind;
      cmd_target = ~cmd_target;
      cmd_value = ~cmd_value;
   endtask
endmodule

// ---- dv/sev_status_events_checker.sv ----
// Checker for the status event register block.
`timescale 1ns/1ps
module sev_status_events_checker #(
   parameter int WIDTH = 16
) (
   input wire logic             clk_sys,
   input wire logic             srst,
   input wire logic             ce,
   input wire logic             cmd_valid,
   input wire logic [3:0]       cmd_kind,
   input wire logic [1:0]       cmd_target,
   input wire logic [WIDTH-1:0] cmd_value,
   input wire logic             layer_active_flag,
   input wire logic             arm_layer_flag,
   input wire logic             arm_stage_one_flag,
   input wire logic             arm_stage_two_flag,
   input wire logic             rsp_valid,
   input wire logic [WIDTH-1:0] rsp_value,
   input wire logic             trig_summary,
   input wire logic             arm_summary,
   input wire logic             seq_summary
);
   logic [3:0][WIDTH-1:0] en;
   logic [3:0][WIDTH-1:0] rf;
   logic [3:0][WIDTH-1:0] ff;
   // ****************************************************************
   // Command decode and register shadows
   // ****************************************************************
   wire logic take = cmd_valid && ce;
   wire logic is_qry = take && (cmd_kind inside {4'h0, 4'h2, 4'h4, 4'h6, 4'h9});
   wire logic is_qen = take && cmd_kind == sev_pkg::CMD_QUERY_ENABLE;
   wire logic [WIDTH-1:0] used_sel = sev_pkg::USED_MASK[cmd_target];
   wire logic [WIDTH-1:0] wval = cmd_value & used_sel;
   wire logic [WIDTH-1:0] en_sel = en[cmd_target];
   wire logic en_t1 = en[1][1];
   // Shadows follow the writes and the preset so checks know each mask.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         en <= '0;
         rf <= sev_pkg::USED_MASK;
         ff <= '0;
      end else if (take) begin
         case (cmd_kind)
            sev_pkg::CMD_WRITE_ENABLE: en[cmd_target] <= wval;
            sev_pkg::CMD_WRITE_RISE: rf[cmd_target] <= wval;
            sev_pkg::CMD_WRITE_FALL: ff[cmd_target] <= wval;
            sev_pkg::CMD_PRESET: begin
               en <= '0;
               rf <= sev_pkg::USED_MASK;
               ff <= '0;
            end
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   AST_RSP_NEXT: assert property (is_qry |=> rsp_valid)
      else $error("Query was not answered in the next cycle.");
   AST_RSP_SOURCE: assert property (rsp_valid && $past(ce) |-> $past(is_qry))
      else $error("Answer appeared without a query.");
   AST_ENABLE_BACK: assert property (is_qen |=> rsp_value == $past(en_sel))
      else $error("Enable query returned a wrong pattern.");
   AST_UNUSED_ZERO: assert property (is_qry |=> (rsp_value & ~$past(used_sel)) == '0)
      else $error("Unused bit read back as one.");
   AST_RSP_HOLD: assert property (!rsp_valid |-> $stable(rsp_value))
      else $error("Answer word changed without a query.");
   AST_TRIG_RISE: assert property ($rose(layer_active_flag) && rf[1][1] && en[1][1]
      |-> ##[1:3] trig_summary)
      else $error("Trigger rise did not reach the summary.");
   AST_ARM_FALL: assert property ($fell(arm_layer_flag) && ff[2][1] && en[2][1]
      |-> ##[1:3] arm_summary)
      else $error("Arm fall did not reach the summary.");
   AST_SEQ_RISE: assert property ($rose(arm_stage_two_flag) && rf[3][2] && en[3][2]
      |-> ##[1:3] seq_summary)
      else $error("Layer two rise did not reach the summary.");
   AST_TRIG_MASK: assert property (trig_summary |-> $past(en_t1) || $past(en_t1, 2))
      else $error("Trigger summary set while masked.");
   // Main scenarios.
   cover property (is_qry ##1 is_qry);
   cover property ($rose(trig_summary));
   cover property (take && cmd_kind == sev_pkg::CMD_PRESET);
endmodule
bind sev_status_events sev_status_events_checker #(.WIDTH(WIDTH)) u_chk (
   .clk_sys(clk_sys), .srst(srst), .ce(ce), .cmd_valid(cmd_valid),
   .cmd_kind(cmd_kind), .cmd_target(cmd_target), .cmd_value(cmd_value),
   .layer_active_flag(layer_active_flag), .arm_layer_flag(arm_layer_flag),
   .arm_stage_one_flag(arm_stage_one_flag), .arm_stage_two_flag(arm_stage_two_flag),
   .rsp_valid(rsp_valid), .rsp_value(rsp_value), .trig_summary(trig_summary),
   .arm_summary(arm_summary), .seq_summary(seq_summary));

// ---- dv/tb_sev_status_events.sv ----
// Self-checking testbench for the status event register block.
`timescale 1ns/1ps
module tb_sev_status_events;
   logic        clk_sys;
   logic        srst;
   logic        ce;
   logic        cmd_valid;
   logic [3:0]  cmd_kind;
   logic [1:0]  cmd_target;
   logic [15:0] cmd_value;
   logic        layer_active_flag;
   logic        arm_layer_flag;
   logic        arm_stage_one_flag;
   logic        arm_stage_two_flag;
   logic        rsp_valid;
   logic [15:0] rsp_value;
   logic [2:0]  sums;
   logic [15:0] exp_q[$];
   logic [15:0] r;
   int          miscompares = 0;
   int          checks = 0;
   int          seed = 9674;
   sev_host_model u_host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
      .cmd_target(cmd_target), .cmd_value(cmd_value));
   sev_status_events u_dut (.clk_sys(clk_sys), .srst(srst), .ce(ce), .cmd_valid(cmd_valid),
      .cmd_kind(cmd_kind), .cmd_target(cmd_target), .cmd_value(cmd_value),
      .layer_active_flag(layer_active_flag), .arm_layer_flag(arm_layer_flag),
      .arm_stage_one_flag(arm_stage_one_flag), .arm_stage_two_flag(arm_stage_two_flag),
      .rsp_valid(rsp_valid), .rsp_value(rsp_value), .trig_summary(sums[0]),
      .arm_summary(sums[1]), .seq_summary(sums[2]));
   // ****************************************************************
   // Clock, compare tasks and answer monitor
   // ****************************************************************
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic chk_rsp(input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("FAIL at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task automatic chk_bit(input logic e, input logic g);
      chk_rsp({15'h0000, e}, {15'h0000, g});
   endtask
   task automatic summarize();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic qry(input logic [3:0] k, input logic [1:0] t, input logic [15:0] e);
      exp_q.push_back(e);
      u_host.send(k, t, 16'h0000);
   endtask
   task automatic wait_sum(input int w);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys);
         #1;
         if (sums[w] === 1'b1) return;
      end
      miscompares++;
      summarize();
   endtask
   task automatic pause(input string s);
      u_host.idle();
      repeat (3) @(posedge clk_sys);
      #1;
      $display("test %s done", s);
   endtask
   // Each answer is matched against the oldest expectation, mid-cycle where it has settled.
   always @(negedge clk_sys) begin
      if (rsp_valid === 1'b1) chk_rsp(exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx,
         rsp_value);
   end
   // A hang ends the run with a mismatch.
   initial begin
      #100000;
      miscompares++;
      summarize();
   end
   // Main sequence.
   initial begin
      {srst, ce} = 2'h3;
      {layer_active_flag, arm_layer_flag, arm_stage_one_flag, arm_stage_two_flag} = 4'h0;
      repeat (8) @(posedge clk_sys);
      #1;
      srst = 1'b0;
      for (int t = 0; t < 4; t++) begin
         qry(sev_pkg::CMD_QUERY_ENABLE, 2'(t), 16'h0000);
         qry(sev_pkg::CMD_QUERY_EVENT, 2'(t), 16'h0000);
      end
      pause("reset");
      for (int t = 0; t < 4; t++) begin
         r = 16'($random(seed));
         u_host.send(sev_pkg::CMD_WRITE_ENABLE, 2'(t), r);
         qry(sev_pkg::CMD_QUERY_ENABLE, 2'(t), r & sev_pkg::USED_MASK[t]);
      end
      u_host.send(sev_pkg::CMD_WRITE_ENABLE, 2'h0, 16'h0462);
      qry(sev_pkg::CMD_QUERY_ENABLE, 2'h0, 16'h0462);
      u_host.send(sev_pkg::CMD_WRITE_ENABLE, 2'h0, 16'h0000);
      qry(sev_pkg::CMD_QUERY_ENABLE, 2'h0, 16'h0000);
      u_host.send(sev_pkg::CMD_WRITE_ENABLE, 2'h1, 16'h0002);
      u_host.send(sev_pkg::CMD_WRITE_ENABLE, 2'h2, 16'h0000);
      pause("enable");
      layer_active_flag = 1'b1;
      wait_sum(0);
      chk_bit(1'b1, sums[0]);
      qry(sev_pkg::CMD_QUERY_EVENT, 2'h1, 16'h0002);
      qry(sev_pkg::CMD_QUERY_EVENT, 2'h1, 16'h0000);
      pause("trigger");
      chk_bit(1'b0, sums[0]);
      arm_layer_flag = 1'b1;
      pause("masked");
      chk_bit(1'b0, sums[1]);
      qry(sev_pkg::CMD_QUERY_EVENT, 2'h2, 16'h0002);
      u_host.send(sev_pkg::CMD_WRITE_RISE, 2'h2, 16'h0000);
      u_host.send(sev_pkg::CMD_WRITE_FALL, 2'h2, 16'h0002);
      u_host.send(sev_pkg::CMD_WRITE_ENABLE, 2'h2, 16'h0002);
      u_host.send(sev_pkg::CMD_WRITE_ENABLE, 2'h3, 16'h0006);
      u_host.idle();
      arm_layer_flag = 1'b0;
      wait_sum(1);
      qry(sev_pkg::CMD_QUERY_EVENT, 2'h2, 16'h0002);
      u_host.idle();
      arm_layer_flag = 1'b1;
      pause("falling");
      qry(sev_pkg::CMD_QUERY_EVENT, 2'h2, 16'h0000);
      u_host.idle();
      {arm_stage_one_flag, arm_stage_two_flag} = 2'h3;
      wait_sum(2);
      qry(sev_pkg::CMD_QUERY_EVENT, 2'h3, 16'h0006);
      u_host.send(sev_pkg::CMD_CLEAR_STATUS, 2'h0, 16'h0000);
      qry(sev_pkg::CMD_QUERY_ENABLE, 2'h3, 16'h0006);
      qry(sev_pkg::CMD_QUERY_COND, 2'h3, 16'h0006);
      qry(sev_pkg::CMD_QUERY_RISE, 2'h2, 16'h0000);
      u_host.send(sev_pkg::CMD_PRESET, 2'h0, 16'h0000);
      qry(sev_pkg::CMD_QUERY_ENABLE, 2'h3, 16'h0000);
      qry(sev_pkg::CMD_QUERY_FALL, 2'h2, 16'h0000);
      qry(sev_pkg::CMD_QUERY_RISE, 2'h2, 16'h0002);
      u_host.send(4'hf, 2'h1, 16'hffff);
      u_host.send(sev_pkg::CMD_WRITE_ENABLE, 2'h1, 16'h0002);
      ce = 1'b0;
      u_host.idle();
      ce = 1'b1;
      qry(sev_pkg::CMD_QUERY_ENABLE, 2'h1, 16'h0000);
      pause("preset");
      layer_active_flag = 1'b0;
      u_host.idle();
      layer_active_flag = 1'b1;
      u_host.send(sev_pkg::CMD_CLEAR_STATUS, 2'h0, 16'h0000);
      qry(sev_pkg::CMD_QUERY_EVENT, 2'h1, 16'h0000);
      pause("clear");
      chk_bit(1'b0, sums[0]);
      if (exp_q.size() != 0) miscompares++;
      summarize();
   end
endmodule
